// *** siw_defs.svh ***
/*
  Constants for the sleep/idle/wake controller: register offsets, field
  positions, reset values and timing counts. Assumes a 40 MHz pclk.
*/
`ifndef SIW_DEFS_SVH
`define SIW_DEFS_SVH
`define SIW_ADDR_WAKE_CTRL 12'h000
`define SIW_ADDR_PWR_CMD 12'h004
`define SIW_ADDR_FLAG5 12'h008
`define SIW_ADDR_STATUS 12'h00C
`define SIW_ADDR_CFG 12'h010
`define SIW_CTRL_EN_BIT 15
`define SIW_CTRL_SIDL_BIT 13
`define SIW_CTRL_SINK_BIT 8
`define SIW_CTRL_RESET 16'h0000
`define SIW_CTRL_MASK 16'hA100
`define SIW_FLAG_WAKE_BIT 0
`define SIW_CMD_SLEEP 2'h1
`define SIW_CMD_IDLE 2'h2
`define SIW_ENTRY_NS 50
`define SIW_ENTRY_CYC ((`SIW_ENTRY_NS + 24) / 25)
`endif

// *** siw_pkg.sv ***
/*
  Types for the sleep/idle/wake controller. Assumes siw_defs.svh.
*/
package siw_pkg;
  typedef enum logic [3:0] {
    SIW_RUN = 4'b0001,
    SIW_ENTER = 4'b0010,
    SIW_SLEEP = 4'b0100,
    SIW_IDLE = 4'b1000
  } siw_state_t;
endpackage : siw_pkg

// *** siw_sync.sv ***
/*
  Two-flop synchroniser for pin-level inputs. Assumes pclk domain.
*/
`timescale 1ns/1ps
module siw_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      dout <= '0;
    end else begin
      s1_r <= din;
      dout <= s1_r;
    end
  end
endmodule : siw_sync

// *** siw_ctrl.sv ***
/*
  Sleep/Idle power-save sequencer with ultra-low-power wake unit, APB slave.
  Assumes presetn is the power-on reset, pclk 40 MHz runs outside Sleep
  gating, and irq/pin inputs come from outside the domain.
*/
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "siw_defs.svh"
module siw_ctrl
  import siw_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_pending,
  input wire logic wdt_timeout,
  input wire logic dev_reset_req,
  input wire logic wake_pin_below_vil,
  input wire logic [2:0] cur_clk_src,
  input wire logic [PINS-1:0] pin_dir_in,
  input wire logic [PINS-1:0] pin_out_in,
  output logic [PINS-1:0] pin_dir_out,
  output logic [PINS-1:0] pin_out_out,
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic osc_en,
  output logic periph_clk_en,
  output logic fail_safe_clock_monitor_en,
  output logic low_power_rc_clock_en,
  output logic wdt_clear,
  output logic [2:0] resume_clk_src,
  output logic wake_sink_on,
  output logic wake_irq_flag,
  output logic dev_reset_out
);
  siw_state_t state_r, state_nxt;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic flag_r, flag_nxt;
  logic is_sleep_r, is_sleep_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [2:0] clk_r, clk_nxt;
  logic [PINS-1:0] dir_r, dir_nxt, out_r, out_nxt;
  logic [2:0] cfg_r, cfg_nxt; // wdt_en, calendar_clock_low_power_rc_clock_en, fail_safe_clock_monitor_cfg
  logic idle_pdis_r, idle_pdis_nxt;
  logic [31:0] prdata_nxt;
  logic irq_s, wdt_s, pin_s;
  logic wr, rd, cmd_sleep, cmd_idle, wake_ev, ulp_live, ulp_wake;

  // Pin-domain inputs through two flops
  siw_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({irq_pending, wdt_timeout, wake_pin_below_vil}),
    .dout({irq_s, wdt_s, pin_s})
  );

  // APB decode: zero-wait, unmapped reads zero, writes dropped, slverr on any read or write above CFG
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr > `SIW_ADDR_CFG);
  assign cmd_sleep = wr && paddr == `SIW_ADDR_PWR_CMD && pwdata[1:0] == `SIW_CMD_SLEEP;
  assign cmd_idle = wr && paddr == `SIW_ADDR_PWR_CMD && pwdata[1:0] == `SIW_CMD_IDLE;

  // Wake unit active when enabled, unless stopped in Idle
  assign ulp_live = ctrl_r[`SIW_CTRL_EN_BIT] &
    ~(state_r == SIW_IDLE & ctrl_r[`SIW_CTRL_SIDL_BIT]);
  assign ulp_wake = ulp_live & pin_s & (state_r == SIW_SLEEP);
  assign wake_ev = irq_s | wdt_s | ulp_wake | dev_reset_req;

  // Next-state, register and flag logic
  always_comb begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    flag_nxt = flag_r;
    is_sleep_nxt = is_sleep_r;
    cnt_nxt = cnt_r;
    clk_nxt = clk_r;
    dir_nxt = dir_r;
    out_nxt = out_r;
    cfg_nxt = cfg_r;
    idle_pdis_nxt = idle_pdis_r;
    wdt_clear = 1'b0;
    if (wr && paddr == `SIW_ADDR_WAKE_CTRL) begin
      ctrl_nxt = pwdata[15:0] & `SIW_CTRL_MASK;
    end
    if (wr && paddr == `SIW_ADDR_CFG) begin
      cfg_nxt = pwdata[2:0];
      idle_pdis_nxt = pwdata[3];
    end
    if (wr && paddr == `SIW_ADDR_FLAG5 && pwdata[`SIW_FLAG_WAKE_BIT]) begin
      flag_nxt = 1'b0;
    end
    if (ulp_wake) begin
      flag_nxt = 1'b1;
    end
    unique case (state_r)
      SIW_RUN: begin
        dir_nxt = pin_dir_in;
        out_nxt = pin_out_in;
        if (cmd_sleep || cmd_idle) begin
          state_nxt = SIW_ENTER;
          is_sleep_nxt = cmd_sleep;
          clk_nxt = cur_clk_src;
          cnt_nxt = 2'(`SIW_ENTRY_CYC);
        end
      end
      SIW_ENTER: begin
        // Keep tracking pins so Sleep freezes the state seen at entry
        dir_nxt = pin_dir_in;
        out_nxt = pin_out_in;
        // Interrupts are held off until entry completes
        if (cnt_r == 2'h1) begin
          wdt_clear = 1'b1;
          state_nxt = is_sleep_r ? SIW_SLEEP : SIW_IDLE;
        end
        cnt_nxt = cnt_r - 2'h1;
      end
      SIW_SLEEP: begin
        if (wake_ev) begin
          state_nxt = SIW_RUN;
        end
      end
      SIW_IDLE: begin
        if (wake_ev) begin
          state_nxt = SIW_RUN;
        end
      end
    endcase
  end

  // Read mux
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    unique case (paddr)
      `SIW_ADDR_WAKE_CTRL: prdata_nxt = {16'h0000, ctrl_r};
      `SIW_ADDR_FLAG5: prdata_nxt = {31'h0, flag_r};
      `SIW_ADDR_STATUS: prdata_nxt = {25'h0, clk_r, state_r};
      `SIW_ADDR_CFG: prdata_nxt = {28'h0, idle_pdis_r, cfg_r};
      default: prdata_nxt = 32'h0000_0000;
    endcase
  end

  // State registers; presetn is the power-on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SIW_RUN;
      ctrl_r <= `SIW_CTRL_RESET;
      flag_r <= 1'b0;
      is_sleep_r <= 1'b0;
      cnt_r <= 2'h0;
      clk_r <= 3'h0;
      dir_r <= '0;
      out_r <= '0;
      cfg_r <= 3'h0;
      idle_pdis_r <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      flag_r <= flag_nxt;
      is_sleep_r <= is_sleep_nxt;
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
      dir_r <= dir_nxt;
      out_r <= out_nxt;
      cfg_r <= cfg_nxt;
      idle_pdis_r <= idle_pdis_nxt;
      if (rd) begin
        prdata <= prdata_nxt;
      end
    end
  end

  // Clock and enable outputs per mode
  assign cpu_clk_en = (state_r == SIW_RUN);
  assign sys_clk_en = (state_r != SIW_SLEEP);
  assign osc_en = (state_r != SIW_SLEEP);
  assign periph_clk_en = (state_r == SIW_RUN) | (state_r == SIW_ENTER) |
    (state_r == SIW_IDLE & ~idle_pdis_r);
  assign fail_safe_clock_monitor_en = cfg_r[2] & (state_r != SIW_SLEEP);
  assign low_power_rc_clock_en = (state_r == SIW_SLEEP) ? (cfg_r[0] | cfg_r[1]) :
    (cfg_r[0] | cfg_r[2]);
  assign pin_dir_out = (state_r == SIW_SLEEP) ? dir_r : pin_dir_in;
  assign pin_out_out = (state_r == SIW_SLEEP) ? out_r : pin_out_in;
  assign resume_clk_src = clk_r;
  assign wake_sink_on = ulp_live & ctrl_r[`SIW_CTRL_SINK_BIT];
  assign wake_irq_flag = flag_r;
  assign dev_reset_out = dev_reset_req;

  // Assertions
  sleep_clk_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_SLEEP |-> !cpu_clk_en && !sys_clk_en && !osc_en)
    else $error("clock running in sleep");
  idle_periph_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_IDLE && !idle_pdis_r |-> sys_clk_en && periph_clk_en && !cpu_clk_en)
    else $error("idle clocks wrong");
  wake_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == SIW_SLEEP || state_r == SIW_IDLE) && wake_ev |=> state_r == SIW_RUN)
    else $error("no wake");
  wdt_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_ENTER && $changed(state_nxt) |-> wdt_clear)
    else $error("watchdog not cleared");
  pin_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_SLEEP && $past(state_r) == SIW_SLEEP |-> $stable(pin_out_out))
    else $error("pins moved in sleep");
  fail_safe_clock_monitor_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_SLEEP |-> !fail_safe_clock_monitor_en) else $error("monitor on in sleep");
  ulp_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ulp_wake |=> flag_r && state_r == SIW_RUN) else $error("wake flag missing");
  entry_defer_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_RUN && (cmd_sleep || cmd_idle) |=> state_r == SIW_ENTER ##1
      state_r == SIW_ENTER ##1 (state_r == SIW_SLEEP || state_r == SIW_IDLE))
    else $error("entry not completed");
  ctrl_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r & ~`SIW_CTRL_MASK) == 16'h0000) else $error("unimplemented bit set");
  // Mode-dependent clock enables
  low_power_rc_clock_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_SLEEP && (cfg_r[0] || cfg_r[1]) |-> low_power_rc_clock_en)
    else $error("rc clock off in sleep");
  periph_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_SLEEP |-> !periph_clk_en)
    else $error("peripherals clocked in sleep");
  idle_sysclk_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_IDLE |-> sys_clk_en && osc_en && (periph_clk_en == !idle_pdis_r))
    else $error("idle system clock wrong");
  idle_low_power_rc_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_IDLE && (cfg_r[0] || cfg_r[2]) |-> low_power_rc_clock_en)
    else $error("rc clock off in idle");
  // Entry and wake sequencing
  idle_wdt_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_ENTER ##1 state_r == SIW_IDLE |-> $past(wdt_clear))
    else $error("watchdog not cleared for idle");
  resume_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_RUN && (cmd_sleep || cmd_idle) |=> resume_clk_src == $past(cur_clk_src))
    else $error("clock source not captured");
  src_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_SLEEP || state_r == SIW_IDLE |-> $stable(resume_clk_src))
    else $error("clock source moved");
  idle_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_IDLE && wake_ev |=> cpu_clk_en)
    else $error("cpu clock not reapplied");
  // Wake unit behaviour
  ulp_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_SLEEP && ctrl_r[`SIW_CTRL_EN_BIT] && pin_s |=> state_r == SIW_RUN && flag_r)
    else $error("wake unit did not wake");
  ulp_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_SLEEP && !ctrl_r[`SIW_CTRL_EN_BIT] && !irq_s && !wdt_s && !dev_reset_req
      |=> state_r == SIW_SLEEP)
    else $error("disabled wake unit woke");
  idle_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == SIW_IDLE && ctrl_r[`SIW_CTRL_SIDL_BIT] |-> !wake_sink_on)
    else $error("wake unit running in idle");
  sink_ctl_a: assert property (@(posedge pclk) disable iff (!presetn)
    wake_sink_on |-> ctrl_r[`SIW_CTRL_SINK_BIT] && ctrl_r[`SIW_CTRL_EN_BIT])
    else $error("sink on without enable");
  sync_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn, 2) |-> pin_s == $past(wake_pin_below_vil, 2))
    else $error("pin crossing not synchronised");
  sleep_cov_c: cover property (@(posedge pclk) state_r == SIW_SLEEP ##1 state_r == SIW_RUN);
  idle_cov_c: cover property (@(posedge pclk) state_r == SIW_IDLE ##1 state_r == SIW_RUN);
  ulp_cov_c: cover property (@(posedge pclk) ulp_wake);
  entry_irq_c: cover property (@(posedge pclk) state_r == SIW_ENTER && irq_s);
  rst_wake_c: cover property (@(posedge pclk) state_r == SIW_IDLE && dev_reset_req);
endmodule : siw_ctrl

// *** siw_rc_net.sv ***
/*
  Behavioural RC network on the wake pin: charged by software, drained by
  the wake unit's current sink. Assumes the pclk domain of the controller.
*/
`timescale 1ns/1ps
module siw_rc_net #(
  parameter int DRAIN_CYC = 40
) (
  input wire logic pclk,
  input wire logic charge,
  input wire logic sink_on,
  output logic below_vil
);
  int lvl = 0;
  // Capacitor level drops only while the sink is drawing current
  always @(posedge pclk) begin
    if (charge) lvl <= DRAIN_CYC;
    else if (sink_on && lvl > 0) lvl <= lvl - 1;
  end
  assign below_vil = (lvl == 0);
endmodule : siw_rc_net

// *** sleep_idle_wake_control_tb_top.sv ***
/*
  Self-checking bench for the sleep/idle/wake controller over APB.
  Assumes siw_defs.svh, siw_pkg and the RC network model.
*/
`timescale 1ns/1ps
`include "siw_defs.svh"
module sleep_idle_wake_control_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, irq_pending = 0, wdt_timeout = 0, below, charge = 0;
  logic dev_reset_req = 0, dev_reset_out, wake_irq_flag;
  logic [2:0] cur_clk_src = 0, resume_clk_src, src_exp;
  logic [7:0] pin_dir_in = 0, pin_out_in = 0, pin_dir_out, pin_out_out, held;
  logic cpu_clk_en, sys_clk_en, osc_en, periph_clk_en, fail_safe_clock_monitor_en, low_power_rc_clock_en;
  logic wdt_clear, wake_sink_on;
  logic [31:0] exp_q[$];
  int err_count = 0, total_checks = 0, clr_cnt = 0;
  siw_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_pending(irq_pending),
    .wdt_timeout(wdt_timeout), .dev_reset_req(dev_reset_req),
    .wake_pin_below_vil(below), .cur_clk_src(cur_clk_src),
    .pin_dir_in(pin_dir_in), .pin_out_in(pin_out_in), .pin_dir_out(pin_dir_out),
    .pin_out_out(pin_out_out), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .osc_en(osc_en), .periph_clk_en(periph_clk_en), .fail_safe_clock_monitor_en(fail_safe_clock_monitor_en),
    .low_power_rc_clock_en(low_power_rc_clock_en), .wdt_clear(wdt_clear), .resume_clk_src(resume_clk_src),
    .wake_sink_on(wake_sink_on), .wake_irq_flag(wake_irq_flag),
    .dev_reset_out(dev_reset_out));
  siw_rc_net i_rc (.pclk(pclk), .charge(charge), .sink_on(wake_sink_on),
    .below_vil(below));
  // Clock generation, 25 ns period
  initial forever #12.5 pclk = ~pclk;
  task conclude;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(0, a, 0);
  endtask : rd
  // Bounded wait for cpu (s=0) or system (s=1) clock enable, seen at each edge
  task wt(input bit s, input logic v);
    int n;
    n = 0;
    while (((s ? sys_clk_en : cpu_clk_en) !== v) && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      conclude();
    end
  endtask : wt
  // Read results compared against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check("rdata", prdata, exp_q.pop_front());
    if (wdt_clear) clr_cnt <= clr_cnt + 1;
  end
  initial begin
    void'($urandom(1));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd(`SIW_ADDR_WAKE_CTRL, 32'h0);
    apb(1, `SIW_ADDR_WAKE_CTRL, 32'hFFFF_FFFF);
    rd(`SIW_ADDR_WAKE_CTRL, 32'h0000_A100);
    rd(12'h020, 32'h0);
    check("slverr", 32'(pslverr), 1);
    apb(1, `SIW_ADDR_CFG, 32'h5);
    // Sleep entered after charging and arming, woken by the RC drain
    cur_clk_src <= 3'($urandom);
    pin_out_in <= 8'($urandom);
    charge <= 1;
    apb(1, `SIW_ADDR_WAKE_CTRL, 32'h0);
    charge <= 0;
    apb(1, `SIW_ADDR_WAKE_CTRL, 32'h0000_8100);
    apb(1, `SIW_ADDR_PWR_CMD, 32'(`SIW_CMD_SLEEP));
    wt(1, 0);
    held = pin_out_in;
    src_exp = cur_clk_src;
    check("cpu", 32'(cpu_clk_en), 0);
    check("osc", 32'(osc_en), 0);
    check("fail_safe_clock_monitor", 32'(fail_safe_clock_monitor_en), 0);
    check("low_power_rc_clock", 32'(low_power_rc_clock_en), 1);
    check("periph", 32'(periph_clk_en), 0);
    check("sink", 32'(wake_sink_on), 1);
    pin_out_in <= ~pin_out_in;
    pin_dir_in <= 8'($urandom) | 8'h01;
    cur_clk_src <= ~cur_clk_src;
    @(posedge pclk);
    check("pins", 32'(pin_out_out), 32'(held));
    check("dirs", 32'(pin_dir_out), 0);
    check("src", 32'(resume_clk_src), 32'(src_exp));
    wt(0, 1);
    check("flag", 32'(wake_irq_flag), 1);
    rd(`SIW_ADDR_STATUS, {25'h0, src_exp, 4'h1});
    rd(`SIW_ADDR_FLAG5, 32'h1);
    apb(1, `SIW_ADDR_FLAG5, 32'h1);
    rd(`SIW_ADDR_FLAG5, 32'h0);
    // Idle with the wake unit stopped, woken by watchdog
    apb(1, `SIW_ADDR_WAKE_CTRL, 32'h0000_A100);
    apb(1, `SIW_ADDR_PWR_CMD, 32'(`SIW_CMD_IDLE));
    wt(0, 0);
    repeat (3) @(posedge pclk);
    check("sys", 32'(sys_clk_en), 1);
    check("periph_i", 32'(periph_clk_en), 1);
    check("low_power_rc_clock_i", 32'(low_power_rc_clock_en), 1);
    check("sink_i", 32'(wake_sink_on), 0);
    wdt_timeout <= 1;
    wt(0, 1);
    wdt_timeout <= 0;
    // Interrupt coinciding with Sleep entry still lets Sleep be reached
    apb(1, `SIW_ADDR_WAKE_CTRL, 32'h0);
    apb(1, `SIW_ADDR_PWR_CMD, 32'(`SIW_CMD_SLEEP));
    irq_pending <= 1;
    wt(1, 0);
    wt(0, 1);
    irq_pending <= 0;
    rd(`SIW_ADDR_FLAG5, 32'h0);
    // Idle with peripherals dropped and monitor on, woken by a device reset
    apb(1, `SIW_ADDR_CFG, 32'hC);
    apb(1, `SIW_ADDR_PWR_CMD, 32'(`SIW_CMD_IDLE));
    wt(0, 0);
    repeat (3) @(posedge pclk);
    check("periph_d", 32'(periph_clk_en), 0);
    check("fail_safe_clock_monitor_i", 32'(fail_safe_clock_monitor_en), 1);
    check("low_power_rc_clock_f", 32'(low_power_rc_clock_en), 1);
    dev_reset_req <= 1;
    wt(0, 1);
    check("rst_out", 32'(dev_reset_out), 1);
    dev_reset_req <= 0;
    // Power-on reset applied in Sleep clears all power-saving state
    apb(1, `SIW_ADDR_WAKE_CTRL, 32'h0000_2000);
    apb(1, `SIW_ADDR_PWR_CMD, 32'(`SIW_CMD_SLEEP));
    wt(1, 0);
    check("clears", 32'(clr_cnt), 32'd5);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    check("por_cpu", 32'(cpu_clk_en), 1);
    check("por_osc", 32'(osc_en), 1);
    presetn <= 1;
    rd(`SIW_ADDR_WAKE_CTRL, 32'h0);
    rd(`SIW_ADDR_CFG, 32'h0);
    rd(`SIW_ADDR_STATUS, 32'h1);
    conclude();
  end
endmodule : sleep_idle_wake_control_tb_top
